/* File: src/iop0_regs.svh */
// Constants of the group-0 shared pad multiplexer: pad counts, signal
// indices, idle levels and reset defaults.
// Assumes inclusion by bare name from the design and bench files.
`ifndef IOP0_REGS_SVH
`define IOP0_REGS_SVH

// ==========================================================
// Package variants and pad counts
`define IOP0_PKG_SMALL 0
`define IOP0_PKG_MIDDLE 1
`define IOP0_PADS_SMALL 12
`define IOP0_PADS_MIDDLE 28
`define IOP0_PADS_LARGE 44
`define IOP0_GROUP_STRIDE 4
`define IOP0_MAX_G0_PADS 11
`define IOP0_PAD_IDX_W 4
`define IOP0_SEL_W 5

// ==========================================================
// Group-0 input list indices
`define IOP0_IN_DEBUG 0
`define IOP0_IN_FD0 1
`define IOP0_IN_FD4 2
`define IOP0_IN_OEN 3
`define IOP0_IN_S0CLK 4
`define IOP0_IN_S1CLK 5
`define IOP0_IN_GPIO0 6
`define IOP0_IN_COUNT 16
// Idle levels: debug line and output-enable idle high, rest low
`define IOP0_IN_IDLE 16'h0009

// ==========================================================
// Group-0 output list indices
`define IOP0_OUT_DEBUG 0
`define IOP0_OUT_TXD 1
`define IOP0_OUT_DTRN 2
`define IOP0_OUT_TXACT 3
`define IOP0_OUT_FD0 4
`define IOP0_OUT_FD4 5
`define IOP0_OUT_RXFN 6
`define IOP0_OUT_PWM0 7
`define IOP0_OUT_PWM4 8
`define IOP0_OUT_MCLK 9
`define IOP0_OUT_MSS1N 10
`define IOP0_OUT_GPIO0 11
`define IOP0_OUT_COUNT 21

// ==========================================================
// Group-0 gpio bits: A0,A4,B0,...,E4 sit every fourth bit
`define IOP0_GPIO_COUNT 10
`define IOP0_GPIO_STEP 4
`define IOP0_GPIO_W 40
`define IOP0_PWM_W 8
`define IOP0_BYTE_W 8
`define IOP0_FD_HI_BIT 4
`define IOP0_SEL_NONE 5'h1F

`endif

/* File: src/iop0_pkg.sv */
// Types shared by the group-0 pad multiplexer files.
// Assumes iop0_regs.svh supplies the numeric constants.
`include "iop0_regs.svh"

package iop0_pkg;

    // ==========================================================
    // Pad direction modes
    typedef enum logic [1:0] {MODE_INPUT, MODE_OUTPUT, MODE_BIDIR} iop0_mode_type;

    // Group-0 pads present in a package variant
    function automatic int g0PadCount(input int variant);
        if (variant == `IOP0_PKG_SMALL) begin
            return `IOP0_PADS_SMALL / `IOP0_GROUP_STRIDE;
        end else if (variant == `IOP0_PKG_MIDDLE) begin
            return `IOP0_PADS_MIDDLE / `IOP0_GROUP_STRIDE;
        end
        return `IOP0_PADS_LARGE / `IOP0_GROUP_STRIDE;
    endfunction : g0PadCount

endpackage : iop0_pkg

/* File: src/iop0_cfg_table.sv */
// Per-pad configuration store for the group-0 multiplexer.
// Assumes configuration writes come from logic on the same clock.
`timescale 1ns/1ps
`include "iop0_regs.svh"

module iop0_cfg_table #(
    parameter int NPAD = 11
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Control
    input wire logic muxEnable,
    input wire logic cfgWe,
    input wire logic [`IOP0_PAD_IDX_W-1:0] cfgPad,
    input wire iop0_pkg::iop0_mode_type cfgMode,
    input wire logic [`IOP0_SEL_W-1:0] cfgInSel,
    input wire logic [`IOP0_SEL_W-1:0] cfgOutSel,
    // Table contents
    output iop0_pkg::iop0_mode_type padMode [`IOP0_MAX_G0_PADS],
    output logic [`IOP0_SEL_W-1:0] padInSel [`IOP0_MAX_G0_PADS],
    output logic [`IOP0_SEL_W-1:0] padOutSel [`IOP0_MAX_G0_PADS]
);

    // ==========================================================
    // Defaults: pad 0 carries the debug line, the rest gpio bits
    function automatic logic [`IOP0_SEL_W-1:0] defSel(input int pad, input int base, input int dbg);
        if (pad == 0) begin
            return dbg[`IOP0_SEL_W-1:0];
        end
        return 5'(base + pad - 1);
    endfunction : defSel

    logic enablePrev_r;
    wire enableRise = muxEnable & ~enablePrev_r;

    // Enable edge detector; defaults load once per enable
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            enablePrev_r <= 1'b0;
        end else begin
            enablePrev_r <= muxEnable;
        end
    end

    // Table: inputs while disabled, defaults on enable, then writes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int p = 0; p < `IOP0_MAX_G0_PADS; p++) begin
                padMode[p] <= iop0_pkg::MODE_INPUT;
                padInSel[p] <= `IOP0_SEL_NONE;
                padOutSel[p] <= `IOP0_SEL_NONE;
            end
        end else begin
            for (int p = 0; p < `IOP0_MAX_G0_PADS; p++) begin
                if (!muxEnable || p >= NPAD) begin
                    padMode[p] <= iop0_pkg::MODE_INPUT;
                    padInSel[p] <= `IOP0_SEL_NONE;
                    padOutSel[p] <= `IOP0_SEL_NONE;
                end else if (enableRise) begin
                    padMode[p] <= iop0_pkg::MODE_BIDIR;
                    padInSel[p] <= defSel(p, `IOP0_IN_GPIO0, `IOP0_IN_DEBUG);
                    padOutSel[p] <= defSel(p, `IOP0_OUT_GPIO0, `IOP0_OUT_DEBUG);
                end else if (cfgWe && int'(cfgPad) == p) begin
                    padMode[p] <= cfgMode;
                    padInSel[p] <= cfgInSel;
                    padOutSel[p] <= cfgOutSel;
                end
            end
        end
    end

endmodule : iop0_cfg_table

/* File: src/iop0_pin_mux.sv */
// Group-0 shared pad multiplexer with the parallel byte-port front end.
// Assumes pads arrive from pins (synchronised here) and peripherals share clk.
`timescale 1ns/1ps
`include "iop0_regs.svh"

module iop0_pin_mux #(
    parameter int PKG_VARIANT = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Configuration
    input wire logic muxEnable,
    input wire logic cfgWe,
    input wire logic [`IOP0_PAD_IDX_W-1:0] cfgPad,
    input wire iop0_pkg::iop0_mode_type cfgMode,
    input wire logic [`IOP0_SEL_W-1:0] cfgInSel,
    input wire logic [`IOP0_SEL_W-1:0] cfgOutSel,
    // Group-0 shared pads, entry i is shared_io_pad 4*i
    input wire logic [`IOP0_MAX_G0_PADS-1:0] padIn,
    output logic [`IOP0_MAX_G0_PADS-1:0] padOut,
    output logic [`IOP0_MAX_G0_PADS-1:0] padOe,
    // Peripheral outputs towards the pads
    input wire logic debugOut,
    input wire logic debugOe,
    input wire logic uartTxd,
    input wire logic uartDtrN,
    input wire logic uartTxActive,
    input wire logic [`IOP0_PWM_W-1:0] pwmOut,
    input wire logic spiMasterClk,
    input wire logic spiMasterSel0N,
    input wire logic spiMasterSel1N,
    input wire logic [`IOP0_GPIO_W-1:0] gpioOut,
    input wire logic [`IOP0_GPIO_W-1:0] gpioOe,
    // Peripheral inputs from the pads
    output logic debugIn,
    output logic slave0SerialClock,
    output logic slave1SerialClock,
    output logic [`IOP0_GPIO_W-1:0] gpioIn,
    output logic spiSel0N,
    // Parallel byte port: strobes and other data bits from other groups
    input wire logic syncMode,
    input wire logic fifoWrN,
    input wire logic fifoRdN,
    input wire logic [`IOP0_BYTE_W-1:0] fifoDataOthersIn,
    // Parallel byte port: buffer side
    input wire logic txFull,
    input wire logic rxAvail,
    input wire logic [`IOP0_BYTE_W-1:0] rxByte,
    output logic wrStrobe,
    output logic [`IOP0_BYTE_W-1:0] wrByte,
    output logic rdAdvance,
    output logic fifoTxeN,
    output logic [`IOP0_BYTE_W-1:0] fifoDataOut,
    output logic fifoDataOe
);

    localparam int NPAD = iop0_pkg::g0PadCount(PKG_VARIANT);

    // ==========================================================
    // Configuration table
    iop0_pkg::iop0_mode_type padMode [`IOP0_MAX_G0_PADS];
    logic [`IOP0_SEL_W-1:0] padInSel [`IOP0_MAX_G0_PADS];
    logic [`IOP0_SEL_W-1:0] padOutSel [`IOP0_MAX_G0_PADS];

    iop0_cfg_table #(.NPAD(NPAD)) cfgTable (
        .clk(clk),
        .resetn(resetn),
        .muxEnable(muxEnable),
        .cfgWe(cfgWe),
        .cfgPad(cfgPad),
        .cfgMode(cfgMode),
        .cfgInSel(cfgInSel),
        .cfgOutSel(cfgOutSel),
        .padMode(padMode),
        .padInSel(padInSel),
        .padOutSel(padOutSel)
    );

    // ==========================================================
    // Pin synchronisers: two flops before any logic looks
    logic [`IOP0_MAX_G0_PADS-1:0] padMeta_r, padSync_r;
    logic [1:0] strobeMeta_r, strobeSync_r;
    logic [`IOP0_BYTE_W-1:0] dataMeta_r, dataSync_r;
    logic wrPrev_r, rdPrev_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            padMeta_r <= '0;
            padSync_r <= '0;
            strobeMeta_r <= 2'h3;
            strobeSync_r <= 2'h3;
            dataMeta_r <= '0;
            dataSync_r <= '0;
        end else begin
            padMeta_r <= padIn;
            padSync_r <= padMeta_r;
            strobeMeta_r <= {fifoRdN, fifoWrN};
            strobeSync_r <= strobeMeta_r;
            dataMeta_r <= fifoDataOthersIn;
            dataSync_r <= dataMeta_r;
        end
    end

    // ==========================================================
    // Input routing: lowest pad wins, idle level when none selects
    logic [`IOP0_IN_COUNT-1:0] inVec;

    always_comb begin
        inVec = `IOP0_IN_IDLE;
        for (int k = 0; k < `IOP0_IN_COUNT; k++) begin
            for (int p = `IOP0_MAX_G0_PADS - 1; p >= 0; p--) begin
                if (p < NPAD && muxEnable && padMode[p] != iop0_pkg::MODE_OUTPUT
                        && int'(padInSel[p]) == k) begin
                    inVec[k] = padSync_r[p];
                end
            end
        end
    end

    // Peripheral inputs; only group-0 gpio bits come through here
    assign debugIn = inVec[`IOP0_IN_DEBUG];
    assign slave0SerialClock = inVec[`IOP0_IN_S0CLK];
    assign slave1SerialClock = inVec[`IOP0_IN_S1CLK];
    assign spiSel0N = spiMasterSel0N; // Select 0 leaves through group 3
    wire oeNEff = syncMode ? inVec[`IOP0_IN_OEN] : 1'b1; // Async ignores it

    generate
        for (genvar g = 0; g < `IOP0_GPIO_W; g++) begin : gGpioIn
            if (g % `IOP0_GPIO_STEP == 0) begin : gRouted
                assign gpioIn[g] = inVec[`IOP0_IN_GPIO0 + g / `IOP0_GPIO_STEP];
            end else begin : gIdle
                assign gpioIn[g] = 1'b0;
            end
        end
    endgenerate

    // ==========================================================
    // Parallel byte port front end
    wire wrNow = strobeSync_r[0];
    wire rdNow = strobeSync_r[1];
    wire wrFall = wrPrev_r & ~wrNow;
    wire rdFall = rdPrev_r & ~rdNow;
    wire [`IOP0_BYTE_W-1:0] dataSampled = {dataSync_r[7:5], inVec[`IOP0_IN_FD4],
        dataSync_r[3:1], inVec[`IOP0_IN_FD0]};

    assign fifoTxeN = txFull; // High means no room
    wire fifoRxfN = ~rxAvail; // Low means a byte waits
    assign fifoDataOe = syncMode ? ~oeNEff : ~rdNow;

    // Strobe edges, capture and read-byte register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrPrev_r <= 1'b1;
            rdPrev_r <= 1'b1;
            wrStrobe <= 1'b0;
            wrByte <= '0;
            rdAdvance <= 1'b0;
            fifoDataOut <= '0;
        end else begin
            wrPrev_r <= wrNow;
            rdPrev_r <= rdNow;
            wrStrobe <= wrFall;
            rdAdvance <= rdFall & rxAvail;
            fifoDataOut <= rxByte;
            if (wrFall) begin
                wrByte <= dataSampled;
            end
        end
    end

    // ==========================================================
    // Output routing; pwm has no input entries at all
    wire [`IOP0_OUT_COUNT-1:0] outVec;
    wire [`IOP0_OUT_COUNT-1:0] outEnVec;
    wire [`IOP0_GPIO_COUNT-1:0] gpioOutG0, gpioOeG0;

    generate
        for (genvar k = 0; k < `IOP0_GPIO_COUNT; k++) begin : gGpioOut
            assign gpioOutG0[k] = gpioOut[k * `IOP0_GPIO_STEP];
            assign gpioOeG0[k] = gpioOe[k * `IOP0_GPIO_STEP];
        end
    endgenerate

    assign outVec = {gpioOutG0, spiMasterSel1N, spiMasterClk,
        pwmOut[`IOP0_FD_HI_BIT], pwmOut[0], fifoRxfN, fifoDataOut[`IOP0_FD_HI_BIT],
        fifoDataOut[0], uartTxActive, uartDtrN, uartTxd, debugOut};
    assign outEnVec = {gpioOeG0, 5'h1F, fifoDataOe, fifoDataOe, 3'h7, debugOe};

    logic [`IOP0_MAX_G0_PADS-1:0] padOutNxt, padOeNxt;

    generate
        for (genvar p = 0; p < `IOP0_MAX_G0_PADS; p++) begin : gPad
            wire selOk = int'(padOutSel[p]) < `IOP0_OUT_COUNT;
            wire live = (p < NPAD) && muxEnable && selOk;
            assign padOutNxt[p] = selOk ? outVec[padOutSel[p]] : 1'b0;
            assign padOeNxt[p] = live && (padMode[p] == iop0_pkg::MODE_OUTPUT
                || (padMode[p] == iop0_pkg::MODE_BIDIR && outEnVec[padOutSel[p]]));
        end
    endgenerate

    // Registered pad drive
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            padOut <= '0;
            padOe <= '0;
        end else begin
            padOut <= padOutNxt;
            padOe <= padOeNxt;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_disabled_inputs;
        !muxEnable |=> padOe == '0;
    endproperty
    a_disabled_inputs: assert property (p_disabled_inputs) else $error("pad driven while disabled");

    // Pads beyond this package's count; a mask keeps the full package legal
    localparam logic [`IOP0_MAX_G0_PADS-1:0] ABSENT_PADS = {`IOP0_MAX_G0_PADS{1'b1}} << NPAD;

    property p_absent_pads;
        (padOe & ABSENT_PADS) == '0;
    endproperty
    a_absent_pads: assert property (p_absent_pads) else $error("absent pad driven");

    property p_wr_capture;
        wrFall |=> wrStrobe && wrByte == $past(dataSampled);
    endproperty
    a_wr_capture: assert property (p_wr_capture) else $error("write byte not captured");

    property p_rd_advance;
        (rdPrev_r && !rdNow) |=> rdAdvance == $past(rxAvail);
    endproperty
    a_rd_advance: assert property (p_rd_advance) else $error("read advance wrong");

    property p_rd_drive;
        !syncMode && !fifoRdN ##2 !syncMode && $stable(fifoRdN) |-> fifoDataOe;
    endproperty
    a_rd_drive: assert property (p_rd_drive) else $error("data not driven on read");

    property p_flags;
        fifoTxeN == txFull && fifoRxfN == !rxAvail;
    endproperty
    a_flags: assert property (p_flags) else $error("space or full flag wrong");

    property p_async_oe;
        !syncMode |-> fifoDataOe == !rdNow;
    endproperty
    a_async_oe: assert property (p_async_oe) else $error("oe used in async mode");

    property p_idle_debug;
        !muxEnable |-> debugIn && !slave0SerialClock;
    endproperty
    a_idle_debug: assert property (p_idle_debug) else $error("unselected input not idle");

    property p_pwm_out;
        muxEnable && padMode[0] == iop0_pkg::MODE_OUTPUT && padOutSel[0] == `IOP0_OUT_PWM0
            |=> padOe[0] && padOut[0] == $past(pwmOut[0]);
    endproperty
    a_pwm_out: assert property (p_pwm_out) else $error("pwm not on pad");

    c_write: cover property (wrFall ##1 wrStrobe);
    c_read: cover property (rdFall && rxAvail);
    c_enable: cover property (!muxEnable ##1 muxEnable ##2 padOe[0]);
    c_sync_drive: cover property (syncMode && fifoDataOe);

endmodule : iop0_pin_mux

/* File: verif/iop0_board_model.sv */
// Board-side model of the group-0 pads and the external byte-port master.
// Assumes its tasks are called on the falling clock edge by the bench.
`timescale 1ns/1ps
`include "iop0_regs.svh"

module iop0_board_model (
    // Clock
    input wire logic clk,
    // Group-0 pads
    input wire logic [`IOP0_MAX_G0_PADS-1:0] padOut,
    input wire logic [`IOP0_MAX_G0_PADS-1:0] padOe,
    output logic [`IOP0_MAX_G0_PADS-1:0] padIn,
    // Byte port pins
    input wire logic fifoTxeN,
    output logic fifoWrN,
    output logic fifoRdN,
    output logic [`IOP0_BYTE_W-1:0] fifoDataOthersIn
);
    logic [`IOP0_MAX_G0_PADS-1:0] boardDrv;

    // ==========================================================
    // Pad wire: board lets go while the device drives, avoiding contention
    assign padIn = (padOe & padOut) | (~padOe & boardDrv);

    // Strobes idle high since they are active low
    initial begin
        boardDrv = '0;
        fifoWrN = 1'b1;
        fifoRdN = 1'b1;
        fifoDataOthersIn = '0;
    end

    // Board level on one pad
    task automatic setPad(input int i, input logic v);
        boardDrv[i] = v;
    endtask : setPad

    // One write; data bits 0 and 4 travel on pads 0 and 1
    task automatic writeByte(input logic [7:0] b);
        int n;
        n = 0;
        while (fifoTxeN !== 1'b0 && n < 50) begin
            @(negedge clk);
            n++;
        end
        boardDrv[0] = b[0];
        boardDrv[1] = b[4];
        fifoDataOthersIn = b;
        @(negedge clk);
        fifoWrN = 1'b0;
        repeat (3) @(negedge clk);
        fifoWrN = 1'b1;
        repeat (2) @(negedge clk);
        // Released data no longer holds the old byte
        fifoDataOthersIn = ~b;
        boardDrv[0] = ~b[0];
        boardDrv[1] = ~b[4];
        // Let an edge pass so a following write sets data on a fresh step
        @(negedge clk);
    endtask : writeByte

    // One read strobe, four cycles low
    task automatic readByte();
        fifoRdN = 1'b0;
        repeat (4) @(negedge clk);
        fifoRdN = 1'b1;
        repeat (3) @(negedge clk);
    endtask : readByte

endmodule : iop0_board_model

/* File: verif/iop0_tb.sv */
// Self-checking bench for the group-0 pad multiplexer.
// Assumes the board model on the pads; inputs change on the falling edge.
`timescale 1ns/1ps
`include "iop0_regs.svh"

module tb;
    logic clk, resetn, muxEnable, cfgWe, syncMode, txFull, rxAvail;
    logic [3:0] cfgPad;
    iop0_pkg::iop0_mode_type cfgMode;
    logic [4:0] cfgInSel, cfgOutSel;
    logic [10:0] padIn, padOut, padOe;
    logic debugOut, debugOe, uartTxd, uartDtrN, uartTxActive, spiMasterClk;
    logic spiMasterSel0N, spiMasterSel1N, debugIn, slave0SerialClock, slave1SerialClock;
    logic spiSel0N, fifoWrN, fifoRdN, wrStrobe, rdAdvance, fifoTxeN, fifoDataOe;
    logic [7:0] pwmOut, fifoDataOthersIn, rxByte, wrByte, fifoDataOut;
    logic [39:0] gpioOut, gpioOe, gpioIn;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int cnt, pad, v;
    int inList[13] = '{0, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15};

    iop0_pin_mux #(.PKG_VARIANT(2)) dut (.clk, .resetn, .muxEnable, .cfgWe, .cfgPad,
        .cfgMode, .cfgInSel, .cfgOutSel, .padIn, .padOut, .padOe, .debugOut, .debugOe,
        .uartTxd, .uartDtrN, .uartTxActive, .pwmOut, .spiMasterClk, .spiMasterSel0N,
        .spiMasterSel1N, .gpioOut, .gpioOe, .debugIn, .slave0SerialClock,
        .slave1SerialClock, .gpioIn, .spiSel0N, .syncMode, .fifoWrN, .fifoRdN,
        .fifoDataOthersIn, .txFull, .rxAvail, .rxByte, .wrStrobe, .wrByte, .rdAdvance,
        .fifoTxeN, .fifoDataOut, .fifoDataOe);

    iop0_board_model board (.clk, .padOut, .padOe, .padIn, .fifoTxeN, .fifoWrN,
        .fifoRdN, .fifoDataOthersIn);

    // ==========================================================
    // Clock and hang guard; ceiling well above the few hundred cycles used
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            results();
        end
    end

    // ==========================================================
    // Helpers
    task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    // Output list order of the group-0 table
    function automatic logic expOut(input int s);
        case (s)
            0: return debugOut;
            1: return uartTxd;
            2: return uartDtrN;
            3: return uartTxActive;
            4: return rxByte[0];
            5: return rxByte[4];
            6: return !rxAvail;
            7: return pwmOut[0];
            8: return pwmOut[4];
            9: return spiMasterClk;
            10: return spiMasterSel1N;
            default: return gpioOut[4*(s-11)];
        endcase
    endfunction : expOut

    task automatic randPeriph();
        {debugOut, debugOe, uartTxd, uartDtrN, uartTxActive} = 5'($urandom);
        {spiMasterClk, spiMasterSel0N, spiMasterSel1N, txFull, rxAvail} = 5'($urandom);
        pwmOut = 8'($urandom);
        rxByte = 8'($urandom);
        gpioOut = {8'($urandom), 32'($urandom)};
        gpioOe = {8'($urandom), 32'($urandom)};
    endtask : randPeriph

    // One table write; returns once padOut and padOe show it
    task automatic cfg(input int p, input iop0_pkg::iop0_mode_type m, input int is, os);
        cfgWe = 1'b1;
        cfgPad = p[3:0];
        cfgMode = m;
        cfgInSel = is[4:0];
        cfgOutSel = os[4:0];
        @(negedge clk);
        cfgWe = 1'b0;
        repeat (2) @(negedge clk);
    endtask : cfg

    task automatic waitStrobe(input logic [7:0] b);
        int n;
        n = 0;
        while (wrStrobe !== 1'b1 && n < 14) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("write strobe", wrStrobe, 1'b1);
        chk("write byte", wrByte, b);
    endtask : waitStrobe

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(9));
        {resetn, muxEnable, cfgWe, syncMode, txFull, rxAvail} = '0;
        {cfgPad, cfgInSel, cfgOutSel} = '0;
        cfgMode = iop0_pkg::MODE_INPUT;
        randPeriph();
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        chk("pads after reset", padOe, 11'h000);
        // Writes while disabled leave every pad an input
        cfg(0, iop0_pkg::MODE_OUTPUT, 31, 1);
        chk("pads while disabled", padOe, 11'h000);
        randPeriph();
        muxEnable = 1'b1;
        repeat (3) @(negedge clk);
        for (int p = 0; p < 11; p++) begin
            if (p == 0) begin
                chk("default oe pad0", padOe[0], debugOe);
            end else begin
                chk("default oe", padOe[p], gpioOe[4*(p-1)]);
                if (gpioOe[4*(p-1)]) chk("default out", padOut[p], gpioOut[4*(p-1)]);
            end
        end
        debugOe = 1'b0;
        board.setPad(0, 1'b0);
        repeat (3) @(negedge clk);
        chk("default debug in", debugIn, 1'b0);
        for (int p = 0; p < 11; p++) cfg(p, iop0_pkg::MODE_INPUT, 31, 31);
        chk("idle debug", debugIn, 1'b1);
        chk("idle slave clocks", {slave0SerialClock, slave1SerialClock}, 2'b00);
        chk("idle gpio", gpioIn, 40'h00_0000_0000);
        // Every output code on a random pad, code 7 on pad 0
        for (int os = 0; os < 21; os++) begin
            pad = (os == 7) ? 0 : $urandom % 11;
            randPeriph();
            cfg(pad, iop0_pkg::MODE_OUTPUT, 31, os);
            chk("out oe", padOe[pad], 1'b1);
            chk("out level", padOut[pad], expOut(os));
            chk("space flag", fifoTxeN, txFull);
            chk("select 0", spiSel0N, spiMasterSel0N);
            cfg(pad, iop0_pkg::MODE_INPUT, 31, 31);
        end
        // Every observable input code on a random pad
        foreach (inList[k]) begin
            pad = $urandom % 11;
            v = $urandom % 2;
            cfg(pad, iop0_pkg::MODE_INPUT, inList[k], 31);
            board.setPad(pad, v[0]);
            repeat (3) @(negedge clk);
            case (inList[k])
                0: chk("in debug", debugIn, v[0]);
                4: chk("in slave0 clock", slave0SerialClock, v[0]);
                5: chk("in slave1 clock", slave1SerialClock, v[0]);
                default: chk("in gpio", gpioIn[4*(inList[k]-6)], v[0]);
            endcase
            cfg(pad, iop0_pkg::MODE_INPUT, 31, 31);
        end
        // Byte writes, data bits 0 and 4 through pads
        txFull = 1'b0;
        cfg(0, iop0_pkg::MODE_INPUT, 1, 31);
        cfg(1, iop0_pkg::MODE_INPUT, 2, 31);
        foreach (inList[k]) begin
            v = (k == 0) ? 0 : (k == 1) ? 255 : $urandom % 256;
            fork
                board.writeByte(v[7:0]);
                waitStrobe(v[7:0]);
            join
        end
        // Reads with and without a byte waiting
        for (int a = 0; a < 2; a++) begin
            rxAvail = a[0];
            rxByte = 8'($urandom);
            cnt = 0;
            fork
                board.readByte();
                for (int i = 1; i <= 8; i++) begin
                    @(posedge clk);
                    #1;
                    cnt += int'(rdAdvance === 1'b1);
                    if (i == 4) chk("read drive", fifoDataOe, 1'b1);
                    if (i == 4) chk("read byte", fifoDataOut, rxByte);
                end
            join
            chk("advance count", cnt, a);
            @(negedge clk);
        end
        // Synchronous mode: drive follows the output-enable pad
        syncMode = 1'b1;
        cfg(2, iop0_pkg::MODE_INPUT, 3, 31);
        for (int i = 0; i < 3; i++) begin
            board.setPad(2, i[0]);
            repeat (3) @(negedge clk);
            chk("sync drive", fifoDataOe, !i[0]);
        end
        syncMode = 1'b0;
        // Disable forces all pads back to inputs
        cfg(3, iop0_pkg::MODE_OUTPUT, 31, 7);
        chk("pad 3 driving", padOe[3], 1'b1);
        muxEnable = 1'b0;
        repeat (3) @(negedge clk);
        chk("pads disabled", padOe, 11'h000);
        results();
    end

endmodule : tb
